/* include/pqu_pkg.sv */
// Shared constants and types of the product/quotient unit
package pqu_pkg;

    localparam int DATA_W   = 32;
    localparam int SLICE_W  = 16;
    localparam int ADDR_W   = 5;
    localparam int REG_NUM  = 32;
    localparam int SETS_NUM = 2;
    localparam int CNT_W    = 6;

    // Early-in sizes of the dividend
    localparam int SIZE_B8  = 8;
    localparam int SIZE_B16 = 16;
    localparam int SIZE_B24 = 24;

    // Iterations skipped per detected dividend size
    localparam logic [CNT_W-1:0] SKIP_B8  = 6'h17;
    localparam logic [CNT_W-1:0] SKIP_B16 = 6'h0f;
    localparam logic [CNT_W-1:0] SKIP_B24 = 6'h07;
    localparam logic [CNT_W-1:0] SKIP_B32 = 6'h00;
    localparam logic [CNT_W-1:0] ITER_FULL = 6'h20;

    // Divide repeat rates; latency is one more
    localparam logic [CNT_W-1:0] REP_B8  = 6'h0b;
    localparam logic [CNT_W-1:0] REP_B16 = 6'h12;
    localparam logic [CNT_W-1:0] REP_B24 = 6'h19;
    localparam logic [CNT_W-1:0] REP_B32 = 6'h20;

    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_TWO = 6'h02;

    typedef enum logic [2:0] {
        OP_PAIR        = 3'h0,
        OP_ACCUMULATE  = 3'h1,
        OP_DEDUCT      = 3'h2,
        OP_QUOTIENT    = 3'h3,
        OP_TO_REGISTER = 3'h4,
        OP_MOVE_UPPER  = 3'h5,
        OP_MOVE_BOTTOM = 3'h6,
        OP_NONE        = 3'h7
    } op_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'h0,
        DIV_RUN  = 2'h1,
        DIV_WAIT = 2'h3
    } div_state_t;

endpackage

/* verif/pipe_issuer.sv */
// Integer pipeline model that offers unit operations and holds them while stalled
`timescale 1ns/1ps
module pipe_issuer
    import pqu_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              stall_reg,
    output logic                   issue_valid,
    output op_t                    issue_op,
    output logic                   issue_signed,
    output logic      [DATA_W-1:0] first_operand,
    output logic      [DATA_W-1:0] second_operand,
    output logic      [ADDR_W-1:0] issue_dest
);
    int waited;
    initial begin
        first_operand = 32'h0;
        second_operand = 32'h0;
        issue_signed = 1'b0;
        idle();
    end
    // Idle operands flip so nothing leans on stale values
    task automatic idle();
        issue_valid = 1'b0;
        issue_op = OP_NONE;
        issue_signed = ~issue_signed;
        first_operand = ~first_operand;
        second_operand = ~second_operand;
        issue_dest = 5'h00;
    endtask
    // Called at a falling edge; returns mid-cycle after the taking edge
    task automatic issue(input op_t op, input logic sg, input logic [31:0] a, input logic [31:0] b,
                         input logic [4:0] d);
        waited = 0;
        issue_valid = 1'b1;
        issue_op = op;
        issue_signed = sg;
        first_operand = a;
        second_operand = b;
        issue_dest = d;
        // Stall is registered, so its mid-cycle value holds at the next edge
        while (stall_reg === 1'b1 && waited < 40) begin
            waited++;
            @(negedge clk_sys);
        end
        @(negedge clk_sys);
    endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench of the product/quotient unit
`timescale 1ns/1ps
module testbench
    import pqu_pkg::*;
;
    logic clk_sys, rst, issue_valid, issue_signed, shadow_select, pipe_write_en, stall_reg, unit_write_reg;
    op_t  issue_op;
    logic [31:0] first_operand, second_operand, pipe_write_data, upper_result_reg, bottom_result_reg;
    logic [31:0] read_a_reg, read_b_reg;
    logic [4:0]  issue_dest, read_a_addr, read_b_addr, pipe_write_addr;
    int error_cnt = 0;
    int n_compared = 0;
    product_quotient_unit dut_u (.clk_sys(clk_sys), .rst(rst), .issue_valid(issue_valid), .issue_op(issue_op),
        .issue_signed(issue_signed), .first_operand(first_operand), .second_operand(second_operand),
        .issue_dest(issue_dest), .shadow_select(shadow_select), .read_a_addr(read_a_addr),
        .read_b_addr(read_b_addr), .pipe_write_en(pipe_write_en), .pipe_write_addr(pipe_write_addr),
        .pipe_write_data(pipe_write_data), .stall_reg(stall_reg), .upper_result_reg(upper_result_reg),
        .bottom_result_reg(bottom_result_reg), .unit_write_reg(unit_write_reg), .read_a_reg(read_a_reg),
        .read_b_reg(read_b_reg));
    pipe_issuer part_u (.clk_sys(clk_sys), .stall_reg(stall_reg), .issue_valid(issue_valid),
        .issue_op(issue_op), .issue_signed(issue_signed), .first_operand(first_operand),
        .second_operand(second_operand), .issue_dest(issue_dest));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic iss(input op_t op, input logic sg, input logic [31:0] a, input logic [31:0] b, input logic [4:0] d);
        part_u.issue(op, sg, a, b, d);
        if (part_u.waited >= 40) begin
            error_cnt++;
            summarize();
        end
    endtask
    task automatic rd_a(input logic [4:0] ad, input logic [31:0] exp);
        read_a_addr = ad;
        @(negedge clk_sys);
        chk({32'h0, read_a_reg}, {32'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_short();
        iss(OP_PAIR, 1'b1, 32'hfffffffd, 32'h00000005, 5'h00);
        chk({upper_result_reg, bottom_result_reg}, 64'hffffffff_fffffff1);
        iss(OP_PAIR, 1'b0, 32'h00010000, 32'h00007fff, 5'h00);
        chk(64'(part_u.waited), 64'h0);
        chk({upper_result_reg, bottom_result_reg}, 64'h00000000_7fff0000);
        iss(OP_ACCUMULATE, 1'b1, 32'h00000002, 32'h00000003, 5'h00);
        chk({upper_result_reg, bottom_result_reg}, 64'h00000000_7fff0006);
        iss(OP_DEDUCT, 1'b1, 32'h00000010, 32'h00000001, 5'h00);
        chk({upper_result_reg, bottom_result_reg}, 64'h00000000_7ffefff6);
        part_u.idle();
    endtask
    task automatic t_full();
        iss(OP_PAIR, 1'b0, 32'h00010000, 32'h00020000, 5'h00);
        iss(OP_PAIR, 1'b0, 32'hffffffff, 32'hffffffff, 5'h00);
        chk(64'(part_u.waited), 64'h1);
        chk({upper_result_reg, bottom_result_reg}, 64'h00000002_00000000);
        part_u.idle();
        @(negedge clk_sys);
        chk({upper_result_reg, bottom_result_reg}, 64'hfffffffe_00000001);
    endtask
    task automatic t_toreg(input logic [31:0] b, input int k_exp, input logic [4:0] d, input logic [31:0] exp);
        int k = 0;
        iss(OP_TO_REGISTER, 1'b1, 32'hfffffffd, b, d);
        part_u.idle();
        while (unit_write_reg !== 1'b1 && k < 5) begin
            @(negedge clk_sys);
            k++;
        end
        chk(64'(k), 64'(k_exp));
        rd_a(d, exp);
    endtask
    task automatic t_divide();
        logic [31:0] dv [6] = '{32'h7f, 32'h7fff, 32'h7fffff, 32'h7fffffff, 32'hffffff9c, 32'hffffff9c};
        logic [31:0] qt [6] = '{32'h12, 32'h1249, 32'h124924, 32'h12492492, 32'hfffffff2, 32'h24924916};
        logic [31:0] rm [6] = '{32'h1, 32'h0, 32'h3, 32'h1, 32'hfffffffe, 32'h2};
        int rv [6] = '{11, 18, 25, 32, 11, 32};
        for (int i = 0; i < 6; i++) begin
            iss(OP_QUOTIENT, (i < 5), dv[i], 32'h00000007, 5'h00);
            iss(OP_MOVE_BOTTOM, 1'b0, 32'h0, 32'h0, 5'(i + 16));
            part_u.idle();
            chk(64'(part_u.waited), 64'(rv[i] - 1));
            chk({upper_result_reg, bottom_result_reg}, {rm[i], qt[i]});
            rd_a(5'(i + 16), qt[i]);
        end
        iss(OP_QUOTIENT, 1'b1, 32'h0000007f, 32'h00000007, 5'h00);
        iss(OP_QUOTIENT, 1'b0, 32'h00000064, 32'h00000007, 5'h00);
        chk(64'(part_u.waited), 64'h0a);
        iss(OP_MOVE_UPPER, 1'b0, 32'h0, 32'h0, 5'h11);
        part_u.idle();
        chk({upper_result_reg, bottom_result_reg}, 64'h00000002_0000000e);
        rd_a(5'h11, 32'h00000002);
    endtask
    task automatic t_regfile();
        pipe_write_en = 1'b1;
        pipe_write_addr = 5'h03;
        pipe_write_data = 32'ha5a5a5a5;
        rd_a(5'h03, 32'ha5a5a5a5);
        shadow_select = 1'b1;
        pipe_write_data = 32'h5a5a5a5a;
        read_b_addr = 5'h03;
        @(negedge clk_sys);
        pipe_write_en = 1'b0;
        chk({32'h0, read_b_reg}, 64'h5a5a5a5a);
        @(negedge clk_sys);
        chk({32'h0, read_b_reg}, 64'h5a5a5a5a);
        shadow_select = 1'b0;
        rd_a(5'h03, 32'ha5a5a5a5);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        shadow_select = 1'b0;
        read_a_addr = 5'h00;
        read_b_addr = 5'h00;
        pipe_write_en = 1'b0;
        pipe_write_addr = 5'h00;
        pipe_write_data = 32'h0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        chk({upper_result_reg, bottom_result_reg}, 64'h0);
        t_short();
        t_full();
        t_toreg(32'h00010000, 1, 5'h09, 32'hfffd0000);
        t_toreg(32'h00000006, 0, 5'h0a, 32'hffffffee);
        t_divide();
        t_regfile();
        summarize();
    end
endmodule

/* verilog/general_register_file.sv */
// General register file with one shadow set, two read ports and a bypassed write port
`timescale 1ns/1ps
module general_register_file
    import pqu_pkg::*;
#(
    parameter int REGS = REG_NUM,
    parameter int SETS = SETS_NUM
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              shadow_select,
    input  wire logic [ADDR_W-1:0] read_a_addr,
    input  wire logic [ADDR_W-1:0] read_b_addr,
    input  wire logic              write_en,
    input  wire logic [ADDR_W-1:0] write_addr,
    input  wire logic [DATA_W-1:0] write_data,
    output logic      [DATA_W-1:0] read_a_reg,
    output logic      [DATA_W-1:0] read_b_reg
);

    logic [DATA_W-1:0] store_reg [SETS*REGS];

    function automatic int slot(input logic set, input logic [ADDR_W-1:0] addr);
        return int'(set) * REGS + int'(addr);
    endfunction

    // Write port, both sets reachable by the set select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < SETS*REGS; i++) begin
                store_reg[i] <= '0;
            end
        end else if (write_en) begin
            store_reg[slot(shadow_select, write_addr)] <= write_data; // RL15
        end
    end

    // Reads take the word being written in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            read_a_reg <= '0;
            read_b_reg <= '0;
        end else begin
            read_a_reg <= (write_en && write_addr == read_a_addr) ? write_data
                        : store_reg[slot(shadow_select, read_a_addr)]; // RL16
            read_b_reg <= (write_en && write_addr == read_b_addr) ? write_data
                        : store_reg[slot(shadow_select, read_b_addr)]; // RL16
        end
    end

    chk_bypass_port_a: assert property (@(posedge clk_sys) disable iff (rst)
        write_en && write_addr == read_a_addr |=> read_a_reg == $past(write_data)) // RL16
        else $error("read port a missed the bypassed write");

    chk_shadow_set_kept: assert property (@(posedge clk_sys) disable iff (rst)
        write_en ##1 !write_en && $stable(shadow_select) && read_b_addr == $past(write_addr)
        |=> read_b_reg == $past(write_data, 2)) // RL15
        else $error("register set lost a written word");

endmodule

/* verilog/product_quotient_unit.sv */
// Product/quotient unit beside the integer pipeline, with its general register file
// Contract
// RL1: The unit runs its own pipeline and keeps advancing while the integer pipeline stalls.
// RL2: Multiplier is Booth-recoded, 32-bit first operand by 16-bit slice per pass.
// RL3: Only the second operand picks one pass (fits 16 bits) or two passes.
// RL4: Short multiply every clock; full multiply every other clock by stalling issue.
// RL5: Divider yields one quotient bit per clock in an iterative state machine.
// RL6: Dividend sign extension skips 23, 15 or 7 iterations for 8, 16, 24 bits.
// RL7: Any unit operation issued during a divide stalls the pipeline until it ends.
// RL8: Pair, accumulate, deduct: latency/repeat 1/1 short, 2/2 full.
// RL9: Multiply to register: latency/repeat 2/1 short, 3/2 full.
// RL10: Divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend size.
// RL11: Pair multiplies and divides fill the result pair; moves copy it to registers.
// RL12: Multiply to register writes the low product word straight to a register.
// RL13: Accumulate adds the product to the result pair.
// RL14: Deduct subtracts the product from the result pair.
// RL15: Thirty-two 32-bit registers plus one full shadow set.
// RL16: Register file has two read ports, one write port, fully bypassed.
// RL17: Unsigned variants use unsigned operands; signed ones two's complement, size detection included.
`timescale 1ns/1ps
module product_quotient_unit
    import pqu_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              issue_valid,
    input  wire op_t               issue_op,
    input  wire logic              issue_signed,
    input  wire logic [DATA_W-1:0] first_operand,
    input  wire logic [DATA_W-1:0] second_operand,
    input  wire logic [ADDR_W-1:0] issue_dest,
    input  wire logic              shadow_select,
    input  wire logic [ADDR_W-1:0] read_a_addr,
    input  wire logic [ADDR_W-1:0] read_b_addr,
    input  wire logic              pipe_write_en,
    input  wire logic [ADDR_W-1:0] pipe_write_addr,
    input  wire logic [DATA_W-1:0] pipe_write_data,
    output logic                   stall_reg,
    output logic      [DATA_W-1:0] upper_result_reg,
    output logic      [DATA_W-1:0] bottom_result_reg,
    output logic                   unit_write_reg,
    output logic      [DATA_W-1:0] read_a_reg,
    output logic      [DATA_W-1:0] read_b_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Does the value fit in w bits, as signed or unsigned
    function automatic logic fits_width(input logic [DATA_W-1:0] v, input logic sgn, input int w);
        logic [DATA_W-1:0] rest;
        rest = sgn ? DATA_W'($signed(v) >>> (w - 1)) : (v >> w);
        return (rest == '0) || (sgn && rest == '1);
    endfunction

    // One radix-4 Booth pass: 33-bit signed by 17-bit signed slice
    function automatic logic signed [49:0] booth_pass(input logic signed [32:0] a, input logic [16:0] b);
        logic signed [49:0] acc;
        logic signed [49:0] pp;
        logic [18:0]        bx;
        acc = '0;
        bx  = {b[16], b, 1'b0};
        for (int i = 0; i < 9; i++) begin
            case (bx[2*i +: 3])
                3'h1, 3'h2: pp = 50'(a);
                3'h3:       pp = 50'(a) <<< 1;
                3'h4:       pp = -(50'(a) <<< 1);
                3'h5, 3'h6: pp = -50'(a);
                default:    pp = '0;
            endcase
            acc = acc + (pp <<< (2 * i));
        end
        return acc;
    endfunction

    function automatic logic [DATA_W-1:0] magnitude(input logic [DATA_W-1:0] v, input logic sgn);
        return (sgn && v[DATA_W-1]) ? DATA_W'(-v) : v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Issue decode

    logic accept;
    logic is_mul;
    logic is_div;
    logic is_move;
    logic short_op;
    assign accept   = issue_valid && !stall_reg; // RL7
    assign is_mul   = issue_op inside {OP_PAIR, OP_ACCUMULATE, OP_DEDUCT, OP_TO_REGISTER};
    assign is_div   = issue_op == OP_QUOTIENT;
    assign is_move  = issue_op inside {OP_MOVE_UPPER, OP_MOVE_BOTTOM};
    assign short_op = fits_width(second_operand, issue_signed, SLICE_W); // RL3 RL17

    logic signed [32:0] a_ext;
    logic        [16:0] slice_low;
    logic signed [63:0] prod_first;
    assign a_ext      = {issue_signed & first_operand[DATA_W-1], first_operand}; // RL17
    assign slice_low  = {short_op & issue_signed & second_operand[SLICE_W-1], second_operand[SLICE_W-1:0]};
    assign prod_first = 64'(booth_pass(a_ext, slice_low)); // RL2

    ////////////////////////////////////////////////////////////////////////////
    // Second multiplier pass

    logic               pass2_reg;
    logic signed [32:0] pass2_a_reg;
    logic        [16:0] pass2_b_reg;
    logic signed [63:0] pass2_low_reg;
    op_t                pass2_op_reg;
    logic [ADDR_W-1:0]  pass2_dest_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pass2_reg      <= 1'b0;
            pass2_a_reg    <= '0;
            pass2_b_reg    <= '0;
            pass2_low_reg  <= '0;
            pass2_op_reg   <= OP_NONE;
            pass2_dest_reg <= '0;
        end else begin
            pass2_reg <= accept && is_mul && !short_op; // RL3
            if (accept && is_mul && !short_op) begin
                pass2_a_reg    <= a_ext;
                pass2_b_reg    <= {issue_signed & second_operand[DATA_W-1], second_operand[DATA_W-1:SLICE_W]};
                pass2_low_reg  <= prod_first;
                pass2_op_reg   <= issue_op;
                pass2_dest_reg <= issue_dest;
            end
        end
    end

    logic               done_valid;
    op_t                done_op;
    logic signed [63:0] done_prod;
    logic [ADDR_W-1:0]  done_dest;

    always_comb begin
        done_valid = pass2_reg || (accept && is_mul && short_op);
        done_op    = pass2_reg ? pass2_op_reg : issue_op;
        done_dest  = pass2_reg ? pass2_dest_reg : issue_dest;
        done_prod  = pass2_reg ? pass2_low_reg + (64'(booth_pass(pass2_a_reg, pass2_b_reg)) <<< SLICE_W)
                               : prod_first; // RL2
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider

    div_state_t        div_state_reg;
    logic [CNT_W-1:0]  div_cnt_reg;
    logic [CNT_W-1:0]  div_iter_reg;
    logic [32:0]       div_rem_reg;
    logic [DATA_W-1:0] div_quo_reg;
    logic [DATA_W-1:0] div_den_reg;
    logic              div_qneg_reg;
    logic              div_rneg_reg;

    logic [CNT_W-1:0] skip;
    logic [CNT_W-1:0] rep;
    always_comb begin
        if (fits_width(first_operand, issue_signed, SIZE_B8)) begin // RL6 RL17
            skip = SKIP_B8;
            rep  = REP_B8; // RL10
        end else if (fits_width(first_operand, issue_signed, SIZE_B16)) begin
            skip = SKIP_B16;
            rep  = REP_B16;
        end else if (fits_width(first_operand, issue_signed, SIZE_B24)) begin
            skip = SKIP_B24;
            rep  = REP_B24;
        end else begin
            skip = SKIP_B32;
            rep  = REP_B32;
        end
    end

    // One restoring step on the magnitudes
    logic [32:0]       step_shift;
    logic [33:0]       step_diff;
    logic [32:0]       step_rem;
    logic [DATA_W-1:0] step_quo;
    always_comb begin
        step_shift = {div_rem_reg[31:0], div_quo_reg[DATA_W-1]};
        step_diff  = {1'b0, step_shift} - {2'b00, div_den_reg};
        step_rem   = step_diff[33] ? step_shift : step_diff[32:0];
        step_quo   = {div_quo_reg[DATA_W-2:0], ~step_diff[33]}; // RL5
    end

    logic [CNT_W-1:0]  div_cnt_next;
    logic              div_write;
    logic [DATA_W-1:0] fin_quo;
    logic [DATA_W-1:0] fin_rem;
    logic [63:0]       div_result;
    always_comb begin
        div_cnt_next = (accept && is_div) ? rep : (div_cnt_reg != '0) ? div_cnt_reg - CNT_ONE : '0;
        div_write    = div_state_reg != DIV_IDLE && div_cnt_reg == CNT_ONE; // RL10
        fin_quo      = (div_iter_reg != '0) ? step_quo : div_quo_reg;
        fin_rem      = (div_iter_reg != '0) ? step_rem[31:0] : div_rem_reg[31:0];
        div_result   = {div_rneg_reg ? DATA_W'(-fin_rem) : fin_rem,
                        div_qneg_reg ? DATA_W'(-fin_quo) : fin_quo};
    end

    // Advances on its own; issue_valid plays no part once running
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_state_reg <= DIV_IDLE;
            div_cnt_reg   <= '0;
            div_iter_reg  <= '0;
            div_rem_reg   <= '0;
            div_quo_reg   <= '0;
            div_den_reg   <= '0;
            div_qneg_reg  <= 1'b0;
            div_rneg_reg  <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next; // RL1
            case (div_state_reg)
                DIV_IDLE: begin
                    div_state_reg <= DIV_IDLE;
                end
                DIV_RUN: begin
                    div_rem_reg  <= step_rem; // RL5
                    div_quo_reg  <= step_quo;
                    div_iter_reg <= div_iter_reg - CNT_ONE;
                    if (div_write) begin
                        div_state_reg <= DIV_IDLE;
                    end else if (div_iter_reg == CNT_ONE) begin
                        div_state_reg <= DIV_WAIT;
                    end
                end
                DIV_WAIT: begin
                    if (div_write) begin
                        div_state_reg <= DIV_IDLE;
                    end
                end
                default: div_state_reg <= DIV_IDLE;
            endcase
            // A divide taken on the finishing edge of the last one reloads at once
            if (accept && is_div) begin
                div_state_reg <= DIV_RUN;
                div_iter_reg  <= ITER_FULL - skip; // RL6
                div_rem_reg   <= '0;
                div_quo_reg   <= magnitude(first_operand, issue_signed) << skip;
                div_den_reg   <= magnitude(second_operand, issue_signed);
                div_qneg_reg  <= issue_signed && (first_operand[DATA_W-1] ^ second_operand[DATA_W-1]);
                div_rneg_reg  <= issue_signed && first_operand[DATA_W-1]; // RL17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result pair, stall and write-back

    // Divide result forwarded so an operation taken on its final edge sees it
    logic [63:0] pair_now;
    logic [63:0] pair_next;
    always_comb begin
        pair_now  = div_write ? div_result : {upper_result_reg, bottom_result_reg}; // RL11
        pair_next = pair_now;
        if (done_valid) begin
            case (done_op)
                OP_PAIR:       pair_next = done_prod; // RL11
                OP_ACCUMULATE: pair_next = pair_now + done_prod; // RL13
                OP_DEDUCT:     pair_next = pair_now - done_prod; // RL14
                default:       pair_next = pair_now;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            upper_result_reg  <= '0;
            bottom_result_reg <= '0;
        end else begin
            {upper_result_reg, bottom_result_reg} <= pair_next; // RL8
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= (accept && is_mul && !short_op) || div_cnt_next >= CNT_TWO; // RL4 RL7
        end
    end

    logic [ADDR_W-1:0] wb_dest_reg;
    logic [DATA_W-1:0] wb_data_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unit_write_reg <= 1'b0;
            wb_dest_reg    <= '0;
            wb_data_reg    <= '0;
        end else begin
            unit_write_reg <= (done_valid && done_op == OP_TO_REGISTER) || (accept && is_move);
            wb_dest_reg    <= done_valid ? done_dest : issue_dest;
            if (done_valid && done_op == OP_TO_REGISTER) begin
                wb_data_reg <= done_prod[DATA_W-1:0]; // RL9 RL12
            end else if (accept && issue_op == OP_MOVE_UPPER) begin
                wb_data_reg <= pair_now[63:32]; // RL11
            end else begin
                wb_data_reg <= pair_now[DATA_W-1:0];
            end
        end
    end

    // Unit write-back owns the single write port while unit_write_reg is high
    general_register_file u_regs (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .shadow_select (shadow_select),
        .read_a_addr   (read_a_addr),
        .read_b_addr   (read_b_addr),
        .write_en      (unit_write_reg || pipe_write_en),
        .write_addr    (unit_write_reg ? wb_dest_reg : pipe_write_addr),
        .write_data    (unit_write_reg ? wb_data_reg : pipe_write_data),
        .read_a_reg    (read_a_reg),
        .read_b_reg    (read_b_reg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic signed [63:0] ref_prod;
    assign ref_prod = issue_signed ? $signed(a_ext) * $signed({second_operand[DATA_W-1], second_operand})
                                   : $signed(64'(first_operand) * 64'(second_operand));

    chk_full_mul_gap: assert property (@(posedge clk_sys) disable iff (rst)
        accept && is_mul && !short_op |=> stall_reg) // RL4
        else $error("full multiply did not hold off the next issue");

    chk_pair_short: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_PAIR && short_op |=> {upper_result_reg, bottom_result_reg} == $past(ref_prod)) // RL8
        else $error("short pair product wrong or late");

    chk_pair_full: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_PAIR && !short_op |=> ##1 {upper_result_reg, bottom_result_reg} == $past(ref_prod, 2)) // RL3
        else $error("full pair product wrong or late");

    chk_accumulate_sum: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_ACCUMULATE && short_op
        |=> {upper_result_reg, bottom_result_reg} == $past(pair_now) + $past(ref_prod)) // RL13
        else $error("accumulate result wrong");

    chk_deduct_diff: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_DEDUCT && short_op
        |=> {upper_result_reg, bottom_result_reg} == $past(pair_now) - $past(ref_prod)) // RL14
        else $error("deduct result wrong");

    chk_to_register: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_TO_REGISTER && !short_op
        |=> !unit_write_reg ##1 unit_write_reg && wb_data_reg == 32'($past(ref_prod, 2))) // RL9
        else $error("multiply to register wrong or late");

    chk_move_upper: assert property (@(posedge clk_sys) disable iff (rst)
        accept && issue_op == OP_MOVE_UPPER |=> unit_write_reg && wb_data_reg == ($past(pair_now) >> DATA_W)) // RL11
        else $error("move from upper result wrong");

    chk_div_stalls: assert property (@(posedge clk_sys) disable iff (rst)
        accept && is_div |=> stall_reg [*8]) // RL7
        else $error("divide did not stall further issue");

    chk_div_byte_lat: assert property (@(posedge clk_sys) disable iff (rst)
        accept && is_div && rep == REP_B8 |=> div_iter_reg == 6'h09 ##10 (div_write && !stall_reg)) // RL6 RL10
        else $error("byte divide skip or latency wrong");

    chk_div_full_lat: assert property (@(posedge clk_sys) disable iff (rst)
        accept && is_div && rep == REP_B32 |-> ##32 div_write) // RL10
        else $error("full divide not finished on time");

    chk_div_advances: assert property (@(posedge clk_sys) disable iff (rst)
        div_state_reg == DIV_RUN && !(accept && is_div) |=> div_iter_reg == $past(div_iter_reg) - 6'h01) // RL1 RL5
        else $error("divider did not advance one bit");

endmodule
